// ==== ppdc_pkg.sv ====
// Constants and types of the port pad pull-up and drive control block
//
// Operation
// - Pull-up bit 7 enables pull-ups on all port K input pins.
// - Pull-up bit 6 enables the debug pin pull-up while it is input.
// - Bit 6 is writable only in special single-chip mode; others always.
// - Pull-up bit 4 enables port E input pull-ups except pins 5 and 6.
// - Port E pins 5 and 6 pull-downs are on only during reset.
// - Pull-up bit 1 enables pull-ups on all port B input pins.
// - Pull-up bit 0 enables pull-ups on all port A input pins.
// - Pull-ups act only on pins configured as inputs, never outputs.
// - Pull-up register resets with K, debug and E on, A and B off.
// - Pull-up register is readable anytime in single-chip modes.
// - Drive bit 7 selects reduced drive for all port K outputs.
// - Drive bit 4 selects reduced drive for all port E outputs.
// - Drive bit 1 selects reduced drive for all port B outputs.
// - Drive bit 0 selects reduced drive for all port A outputs.
// - Reduced drive asserts the port's pad drive-select, about one fifth.
// - Reduced drive applies to outputs of any function; none on inputs.
// - Drive register is readable and writable anytime, any mode.
// - Direction bit 1 means output, 0 means input; gates both settings.
`default_nettype none

package ppdc_pkg;

  // ****************************
  // Register map
  // ****************************
  localparam int          PPDC_ADDR_W        = 12;
  localparam logic [11:0] PPDC_PULL_UP_OFF   = 12'h00c;
  localparam logic [11:0] PPDC_RED_DRIVE_OFF = 12'h010;
  localparam logic [11:0] PPDC_STATUS_OFF    = 12'h014;

  // ****************************
  // Field positions
  // ****************************
  localparam int PPDC_PU_PORT_K_POS = 7;
  localparam int PPDC_PU_DEBUG_POS  = 6;
  localparam int PPDC_PU_PORT_E_POS = 4;
  localparam int PPDC_PU_PORT_B_POS = 1;
  localparam int PPDC_PU_PORT_A_POS = 0;
  localparam int PPDC_RD_PORT_K_POS = 7;
  localparam int PPDC_RD_PORT_E_POS = 4;
  localparam int PPDC_RD_PORT_B_POS = 1;
  localparam int PPDC_RD_PORT_A_POS = 0;

  // ****************************
  // Masks and reset values
  // ****************************
  localparam logic [7:0] PPDC_PU_IMPL_MASK  = 8'hd3;
  localparam logic [7:0] PPDC_PU_DEBUG_MASK = 8'h40;
  localparam logic [7:0] PPDC_RD_IMPL_MASK  = 8'h93;
  localparam logic [7:0] PPDC_PU_RESET      = 8'hd0;
  localparam logic [7:0] PPDC_RD_RESET      = 8'h00;
  localparam logic [7:0] PPDC_ALL_PINS      = 8'hff;
  localparam logic [7:0] PPDC_PORT_E_PU_PINS = 8'h9f;

  // ****************************
  // Modes and states
  // ****************************
  typedef enum logic [1:0] {
    PPDC_MODE_SPECIAL_SINGLE  = 2'h0,
    PPDC_MODE_NORMAL_SINGLE   = 2'h1,
    PPDC_MODE_NORMAL_EXPANDED = 2'h2,
    PPDC_MODE_SPECIAL_TEST    = 2'h3
  } ppdc_mode_t;

  typedef enum logic [1:0] {
    PPDC_BUS_IDLE   = 2'b01,
    PPDC_BUS_ANSWER = 2'b10
  } ppdc_bus_t;

endpackage : ppdc_pkg

`default_nettype wire

// ==== ppdc_pad_gate.sv ====
// Per-pin pad gating of pull-up and reduced drive by pin direction
`default_nettype none

module ppdc_pad_gate #(
  parameter int         WIDTH   = 8,
  parameter logic [7:0] PU_PINS = 8'hff
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic             pullup_en,
  input  wire logic             weak_en,
  output var  logic [WIDTH-1:0] pad_pullup,
  output var  logic [WIDTH-1:0] pad_weak
);

  genvar i;

  // ****************************
  // One pad slice per pin
  // ****************************
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      wire logic is_input;
      wire logic nxt_pullup;
      wire logic nxt_weak;
      logic      pullup_ff;
      logic      weak_ff;

      assign is_input   = ~dir[i];
      assign nxt_pullup = pullup_en & is_input & PU_PINS[i];
      assign nxt_weak   = weak_en & dir[i];

      always_ff @(posedge clock) begin
        if (!resetn) begin
          pullup_ff <= 1'b0;
          weak_ff   <= 1'b0;
        end else begin
          pullup_ff <= nxt_pullup;
          weak_ff   <= nxt_weak;
        end
      end

      assign pad_pullup[i] = pullup_ff;
      assign pad_weak[i]   = weak_ff;
    end
  endgenerate

endmodule : ppdc_pad_gate

`default_nettype wire

// ==== ppdc_top.sv ====
// Port pad pull-up and reduced drive control with APB register access
`default_nettype none

module ppdc_top
  import ppdc_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic [1:0]       mode_sel,
  input  wire logic [7:0]       dir_port_a,
  input  wire logic [7:0]       dir_port_b,
  input  wire logic [7:0]       dir_port_e,
  input  wire logic [7:0]       dir_port_k,
  input  wire logic             debug_pin_dir,
  output var  logic [7:0]       pad_pullup_a,
  output var  logic [7:0]       pad_pullup_b,
  output var  logic [7:0]       pad_pullup_e,
  output var  logic [7:0]       pad_pullup_k,
  output var  logic             pad_pullup_debug,
  output var  logic [7:0]       pad_weak_a,
  output var  logic [7:0]       pad_weak_b,
  output var  logic [7:0]       pad_weak_e,
  output var  logic [7:0]       pad_weak_k,
  output var  logic [1:0]       pad_pulldown_e56
);

  // ****************************
  // Declarations
  // ****************************
  ppdc_bus_t   state_ff;
  ppdc_bus_t   nxt_state;
  logic [7:0]  pull_up_ff;
  logic [7:0]  drive_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        pulldown_ff;

  wire logic       setup;
  wire logic       commit;
  wire logic       commit_wr;
  wire logic       lane0;
  wire logic       hit_pu;
  wire logic       hit_rd;
  wire logic       hit_st;
  wire logic       mapped;
  wire logic       single_chip;
  wire logic       special_single;
  wire logic [7:0] pu_wr_mask;
  wire logic [7:0] nxt_pull_up;
  wire logic [7:0] nxt_drive;
  wire logic [7:0] pu_read;
  wire logic [7:0] status_read;
  wire logic [7:0] read_byte;
  wire logic [31:0] nxt_prdata;
  wire logic       port_a_pullup_en;
  wire logic       port_b_pullup_en;
  wire logic       port_e_pullup_en;
  wire logic       port_k_pullup_en;
  wire logic       debug_pin_pullup_en;
  wire logic       port_a_weak_drive;
  wire logic       port_b_weak_drive;
  wire logic       port_e_weak_drive;
  wire logic       port_k_weak_drive;

  // ****************************
  // Mode decode
  // ****************************
  assign special_single = (mode_sel == PPDC_MODE_SPECIAL_SINGLE);
  assign single_chip    = special_single
                        | (mode_sel == PPDC_MODE_NORMAL_SINGLE);

  // ****************************
  // APB decode
  // ****************************
  assign setup     = psel & ~penable & (state_ff == PPDC_BUS_IDLE);
  assign commit    = psel & penable & pready_ff;
  assign lane0     = pstrb[0];
  assign commit_wr = commit & pwrite & lane0 & ~pslverr_ff;
  assign hit_pu    = (paddr == PPDC_PULL_UP_OFF);
  assign hit_rd    = (paddr == PPDC_RED_DRIVE_OFF);
  assign hit_st    = (paddr == PPDC_STATUS_OFF);
  assign mapped    = hit_pu | hit_rd | hit_st;

  // ****************************
  // Bus state machine
  // ****************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PPDC_BUS_IDLE: begin
        if (setup) begin
          nxt_state = PPDC_BUS_ANSWER;
        end
      end
      PPDC_BUS_ANSWER: begin
        if (commit || !psel) begin
          nxt_state = PPDC_BUS_IDLE;
        end
      end
      default: begin
        nxt_state = PPDC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff <= PPDC_BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************
  // Pull-up control register
  // ****************************
  // Debug bit locked outside special single-chip mode
  assign pu_wr_mask = special_single ? PPDC_PU_IMPL_MASK
                                     : (PPDC_PU_IMPL_MASK & ~PPDC_PU_DEBUG_MASK);

  assign nxt_pull_up = (pull_up_ff & ~pu_wr_mask)
                     | (pwdata[7:0] & pu_wr_mask);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pull_up_ff <= PPDC_PU_RESET;
    end else if (commit_wr && hit_pu) begin
      pull_up_ff <= nxt_pull_up;
    end
  end

  // ****************************
  // Reduced drive register
  // ****************************
  assign nxt_drive = pwdata[7:0] & PPDC_RD_IMPL_MASK;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      drive_ff <= PPDC_RD_RESET;
    end else if (commit_wr && hit_rd) begin
      drive_ff <= nxt_drive;
    end
  end

  // ****************************
  // Read path
  // ****************************
  // Outside single-chip modes the pull-up register reads zero
  assign pu_read     = single_chip ? pull_up_ff : 8'h00;
  assign status_read = {4'h0, pulldown_ff, pad_pullup_debug, mode_sel};
  assign read_byte   = hit_pu ? pu_read
                     : hit_rd ? drive_ff
                     : hit_st ? status_read
                     : 8'h00;
  assign nxt_prdata  = {24'h000000, read_byte};

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff  <= pwrite ? 32'h00000000 : nxt_prdata;
      pready_ff  <= 1'b1;
      pslverr_ff <= ~mapped | (pwrite & hit_st);
    end else if (commit || !psel) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************
  // Field decode
  // ****************************
  assign port_k_pullup_en    = pull_up_ff[PPDC_PU_PORT_K_POS];
  assign debug_pin_pullup_en = pull_up_ff[PPDC_PU_DEBUG_POS];
  assign port_e_pullup_en    = pull_up_ff[PPDC_PU_PORT_E_POS];
  assign port_b_pullup_en    = pull_up_ff[PPDC_PU_PORT_B_POS];
  assign port_a_pullup_en    = pull_up_ff[PPDC_PU_PORT_A_POS];
  assign port_k_weak_drive   = drive_ff[PPDC_RD_PORT_K_POS];
  assign port_e_weak_drive   = drive_ff[PPDC_RD_PORT_E_POS];
  assign port_b_weak_drive   = drive_ff[PPDC_RD_PORT_B_POS];
  assign port_a_weak_drive   = drive_ff[PPDC_RD_PORT_A_POS];

  // ****************************
  // Port E reset pull-downs
  // ****************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pulldown_ff <= 1'b1;
    end else begin
      pulldown_ff <= 1'b0;
    end
  end

  assign pad_pulldown_e56 = {pulldown_ff, pulldown_ff};

  // ****************************
  // Pad gating per port
  // ****************************
  ppdc_pad_gate #(
    .WIDTH   (8),
    .PU_PINS (PPDC_ALL_PINS)
  ) u_port_a (
    .clock      (clock),
    .resetn     (resetn),
    .dir        (dir_port_a),
    .pullup_en  (port_a_pullup_en),
    .weak_en    (port_a_weak_drive),
    .pad_pullup (pad_pullup_a),
    .pad_weak   (pad_weak_a)
  );

  ppdc_pad_gate #(
    .WIDTH   (8),
    .PU_PINS (PPDC_ALL_PINS)
  ) u_port_b (
    .clock      (clock),
    .resetn     (resetn),
    .dir        (dir_port_b),
    .pullup_en  (port_b_pullup_en),
    .weak_en    (port_b_weak_drive),
    .pad_pullup (pad_pullup_b),
    .pad_weak   (pad_weak_b)
  );

  // Pins 5 and 6 never take the pull-up
  ppdc_pad_gate #(
    .WIDTH   (8),
    .PU_PINS (PPDC_PORT_E_PU_PINS)
  ) u_port_e (
    .clock      (clock),
    .resetn     (resetn),
    .dir        (dir_port_e),
    .pullup_en  (port_e_pullup_en),
    .weak_en    (port_e_weak_drive),
    .pad_pullup (pad_pullup_e),
    .pad_weak   (pad_weak_e)
  );

  ppdc_pad_gate #(
    .WIDTH   (8),
    .PU_PINS (PPDC_ALL_PINS)
  ) u_port_k (
    .clock      (clock),
    .resetn     (resetn),
    .dir        (dir_port_k),
    .pullup_en  (port_k_pullup_en),
    .weak_en    (port_k_weak_drive),
    .pad_pullup (pad_pullup_k),
    .pad_weak   (pad_weak_k)
  );

  // Debug pin has no drive-strength control
  ppdc_pad_gate #(
    .WIDTH   (1),
    .PU_PINS (PPDC_ALL_PINS)
  ) u_debug_pin (
    .clock      (clock),
    .resetn     (resetn),
    .dir        (debug_pin_dir),
    .pullup_en  (debug_pin_pullup_en),
    .weak_en    (1'b0),
    .pad_pullup (pad_pullup_debug),
    .pad_weak   ()
  );

endmodule : ppdc_top

`default_nettype wire

// ==== ppdc_properties.sv ====
// Port-level assertions for the pad control block
`default_nettype none

module ppdc_properties (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [1:0]  mode_sel,
  input wire logic [7:0]  dir_port_a,
  input wire logic [7:0]  dir_port_b,
  input wire logic [7:0]  dir_port_e,
  input wire logic [7:0]  dir_port_k,
  input wire logic        debug_pin_dir,
  input wire logic [7:0]  pad_pullup_a,
  input wire logic [7:0]  pad_pullup_b,
  input wire logic [7:0]  pad_pullup_e,
  input wire logic [7:0]  pad_pullup_k,
  input wire logic        pad_pullup_debug,
  input wire logic [7:0]  pad_weak_a,
  input wire logic [7:0]  pad_weak_b,
  input wire logic [7:0]  pad_weak_e,
  input wire logic [7:0]  pad_weak_k,
  input wire logic [1:0]  pad_pulldown_e56
);
  // ****************************
  // Properties
  // ****************************
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  pulldown_rst_a: assert property (disable iff (1'b0) !resetn |=> pad_pulldown_e56 == 2'b11)
    else $error("pull-downs off in reset");
  pulldown_off_a: assert property ($past(resetn) |-> pad_pulldown_e56 == 2'b00)
    else $error("pull-downs on after reset");
  pullup_dir_a: assert property ($past(resetn) |-> ((pad_pullup_a & $past(dir_port_a))
    | (pad_pullup_b & $past(dir_port_b)) | (pad_pullup_e & $past(dir_port_e))
    | (pad_pullup_k & $past(dir_port_k))) == 8'h00) else $error("pull-up on output");
  weak_dir_a: assert property ($past(resetn) |-> ((pad_weak_a & ~$past(dir_port_a))
    | (pad_weak_b & ~$past(dir_port_b)) | (pad_weak_e & ~$past(dir_port_e))
    | (pad_weak_k & ~$past(dir_port_k))) == 8'h00) else $error("weak drive on input");
  port_e_pins_a: assert property (pad_pullup_e[6:5] == 2'b00)
    else $error("pull-up on port E pin 5 or 6");
  pullup_even_a: assert property ($past(resetn) |->
    pad_pullup_a == ({8{|pad_pullup_a}} & ~$past(dir_port_a))
    && pad_pullup_b == ({8{|pad_pullup_b}} & ~$past(dir_port_b))
    && pad_pullup_e == ({8{|pad_pullup_e}} & 8'h9f & ~$past(dir_port_e))
    && pad_pullup_k == ({8{|pad_pullup_k}} & ~$past(dir_port_k))) else $error("pull-up uneven");
  weak_even_a: assert property ($past(resetn) |->
    pad_weak_a == ({8{|pad_weak_a}} & $past(dir_port_a))
    && pad_weak_b == ({8{|pad_weak_b}} & $past(dir_port_b))
    && pad_weak_e == ({8{|pad_weak_e}} & $past(dir_port_e))
    && pad_weak_k == ({8{|pad_weak_k}} & $past(dir_port_k))) else $error("weak drive uneven");
  debug_gate_a: assert property (pad_pullup_debug |-> !$past(debug_pin_dir))
    else $error("debug pull-up while output");
  debug_lock_a: assert property (pready && pwrite && paddr == 12'h00c && mode_sel != 2'h0
    && !debug_pin_dir |-> ##2 ($stable(pad_pullup_debug) || $past(debug_pin_dir)))
    else $error("debug pull-up written outside special mode");
  unimpl_zero_a: assert property (pready && !pwrite && (paddr == 12'h00c || paddr == 12'h010)
    |-> (prdata & (paddr == 12'h010 ? 32'hffffff6c : 32'hffffff2c)) == 32'h0)
    else $error("unimplemented bit reads one");
  mode_read_a: assert property (pready && !pwrite && paddr == 12'h00c && mode_sel[1]
    |-> prdata == 32'h0) else $error("pull-up readable outside single-chip");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
endmodule : ppdc_properties

bind ppdc_top ppdc_properties i_ppdc_properties (.clock, .resetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .mode_sel, .dir_port_a, .dir_port_b, .dir_port_e, .dir_port_k,
  .debug_pin_dir, .pad_pullup_a, .pad_pullup_b, .pad_pullup_e, .pad_pullup_k,
  .pad_pullup_debug, .pad_weak_a, .pad_weak_b, .pad_weak_e, .pad_weak_k, .pad_pulldown_e56);

`default_nettype wire

// ==== ppdc_pad_model.sv ====
// Pad cell model: pin level from drive, pull-up and pull-down
`default_nettype none

module ppdc_pad_model (
  input  wire logic       clock,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] out_val,
  input  wire logic [7:0] pu_on,
  input  wire logic [7:0] pd_on,
  output var  logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_ff = 8'h55;

  // Undriven lines wander
  always @(posedge clock) float_ff <= ~float_ff;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dir[i]) pin[i] = out_val[i];
      else if (pu_on[i]) pin[i] = 1'b1;
      else if (pd_on[i]) pin[i] = 1'b0;
      else pin[i] = float_ff[i];
    end
  end
endmodule : ppdc_pad_model

`default_nettype wire

// ==== test_port_pad_pullup_drive_ctrl.sv ====
// Self-checking bench of the pad control block
`default_nettype none

module test_port_pad_pullup_drive_ctrl
  import ppdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr, debug_pin_dir;
  logic        pad_pullup_debug;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [1:0]  mode_sel, pad_pulldown_e56;
  logic [7:0]  dir_port_a, dir_port_b, dir_port_e, dir_port_k, pin_e, pu, rdv;
  logic [7:0]  pad_pullup_a, pad_pullup_b, pad_pullup_e, pad_pullup_k;
  logic [7:0]  pad_weak_a, pad_weak_b, pad_weak_e, pad_weak_k;
  int          failures, n_compared, cycles;

  ppdc_top i_ppdc_top (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mode_sel, .dir_port_a, .dir_port_b, .dir_port_e,
    .dir_port_k, .debug_pin_dir, .pad_pullup_a, .pad_pullup_b, .pad_pullup_e, .pad_pullup_k,
    .pad_pullup_debug, .pad_weak_a, .pad_weak_b, .pad_weak_e, .pad_weak_k, .pad_pulldown_e56);
  ppdc_pad_model i_ppdc_pad_model (.clock, .dir(dir_port_e), .out_val(8'ha5),
    .pu_on(pad_pullup_e), .pd_on({1'b0, pad_pulldown_e56, 5'h00}), .pin(pin_e));

  // ****************************
  // Tasks
  // ****************************
  always #50 clock = ~clock;

  task automatic finish_test;
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [7:0] exp_d, input logic exp_e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    check("prdata", exp_d, prdata[7:0]);
    check("prdata_hi", 8'h00, {7'h0, |prdata[31:8]});
    check("pslverr", {7'h0, exp_e}, {7'h0, pslverr});
  endtask : acc

  task automatic idle(input int c);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (c) @(posedge clock);
  endtask : idle

  task automatic chk_pads;
    check("pullup_a", {8{pu[0]}} & ~dir_port_a, pad_pullup_a);
    check("pullup_b", {8{pu[1]}} & ~dir_port_b, pad_pullup_b);
    check("pullup_e", {8{pu[4]}} & 8'h9f & ~dir_port_e, pad_pullup_e);
    check("pullup_k", {8{pu[7]}} & ~dir_port_k, pad_pullup_k);
    check("pullup_dbg", {7'h0, pu[6] & ~debug_pin_dir}, {7'h0, pad_pullup_debug});
    check("weak_a", {8{rdv[0]}} & dir_port_a, pad_weak_a);
    check("weak_b", {8{rdv[1]}} & dir_port_b, pad_weak_b);
    check("weak_e", {8{rdv[4]}} & dir_port_e, pad_weak_e);
    check("weak_k", {8{rdv[7]}} & dir_port_k, pad_weak_k);
  endtask : chk_pads

  // ****************************
  // Sequence
  // ****************************
  initial begin
    {clock, resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {mode_sel, debug_pin_dir, failures, n_compared, cycles} = {2'h1, 1'b0, 96'h0};
    {dir_port_a, dir_port_b, dir_port_e, dir_port_k} = 32'h0ff08181;
    repeat (16) @(posedge clock);
    check("pulldown_rst", 8'h03, {6'h0, pad_pulldown_e56});
    check("pin_e56_rst", 8'h00, {6'h0, pin_e[6:5]});
    resetn <= 1'b1;
    idle(2);
    check("pulldown_run", 8'h00, {6'h0, pad_pulldown_e56});
    check("pin_e4", 8'h01, {7'h0, pin_e[4]});
    {pu, rdv} = {8'hd0, 8'h00};
    chk_pads();
    acc(1'b0, 12'h00c, 32'h0, 4'h1, 8'hd0, 1'b0);
    acc(1'b0, 12'h010, 32'h0, 4'h1, 8'h00, 1'b0);
    acc(1'b1, 12'h00c, 32'h0, 4'h1, 8'h00, 1'b0);
    acc(1'b0, 12'h00c, 32'h0, 4'h1, 8'h40, 1'b0);
    acc(1'b1, 12'h00c, 32'hffffffff, 4'hf, 8'h00, 1'b0);
    acc(1'b0, 12'h00c, 32'h0, 4'h1, 8'hd3, 1'b0);
    acc(1'b1, 12'h010, 32'hffffffff, 4'h1, 8'h00, 1'b0);
    acc(1'b0, 12'h010, 32'h0, 4'h1, 8'h93, 1'b0);
    {pu, rdv} = {8'hd3, 8'h93};
    idle(2);
    chk_pads();
    {dir_port_a, dir_port_b, dir_port_e, dir_port_k, debug_pin_dir} <= {32'hf00f7e18, 1'b1};
    idle(2);
    chk_pads();
    for (int m = 3; m >= 0; m--) begin
      mode_sel <= m[1:0];
      pu = (m == 0) ? 8'h00 : 8'h40;
      rdv = (8'hff >> m) & 8'h93;
      acc(1'b1, 12'h00c, 32'h0, 4'h1, 8'h00, 1'b0);
      acc(1'b0, 12'h00c, 32'h0, 4'h1, m > 1 ? 8'h00 : pu, 1'b0);
      acc(1'b1, 12'h010, {24'h0, 8'hff >> m}, 4'h1, 8'h00, 1'b0);
      acc(1'b0, 12'h010, 32'h0, 4'h1, rdv, 1'b0);
    end
    debug_pin_dir <= 1'b0;
    idle(2);
    chk_pads();
    acc(1'b1, 12'h00c, 32'hff, 4'h0, 8'h00, 1'b0);
    acc(1'b0, 12'h00c, 32'h0, 4'h1, 8'h00, 1'b0);
    acc(1'b0, 12'h004, 32'h0, 4'h1, 8'h00, 1'b1);
    acc(1'b1, 12'h014, 32'hff, 4'h1, 8'h00, 1'b1);
    resetn <= 1'b0;
    idle(3);
    check("pulldown_rst2", 8'h03, {6'h0, pad_pulldown_e56});
    resetn <= 1'b1;
    idle(2);
    {pu, rdv} = {8'hd0, 8'h00};
    chk_pads();
    acc(1'b0, 12'h00c, 32'h0, 4'h1, 8'hd0, 1'b0);
    idle(1);
    finish_test();
  end
endmodule : test_port_pad_pullup_drive_ctrl

`default_nettype wire
